// [rtl/rtc_params.svh]
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_OFS_CFG   4'h0
`define RTC_OFS_PAD   4'h4
`define RTC_OFS_VAL   4'h8
`define RTC_EN_BIT    15
`define RTC_WREN_BIT  13
`define RTC_SYNC_BIT  12
`define RTC_HALF_BIT  11
`define RTC_OE_BIT    10
`define RTC_PTR_HI    9
`define RTC_PTR_LO    8
`define RTC_CAL_HI    7
`define RTC_SEL_BIT   1
`define RTC_PMP_BIT   0
`define RTC_PTR_MINUTES_SECONDS_FIELD 2'h0
`define RTC_PTR_RSVD   2'h3
`define RTC_PTR_STEP   2'h1
`define RTC_SEC_MAX   8'h3B
`define RTC_MIN_MAX   8'h3B
`define RTC_HOUR_MAX  8'h17
`define RTC_WDAY_MAX  8'h06
`define RTC_DAY_MAX   8'h1F
`define RTC_DAY_MIN   8'h01
`define RTC_MON_MAX   8'h0C
`define RTC_MON_MIN   8'h01
`define RTC_FIELD_ONE 8'h01
`define RTC_CLK_HZ    64'd25000000
`define RTC_SECOND_MS 64'd1000
`define RTC_MS_PER_S  64'd1000
`define RTC_SECOND_CYCLES (`RTC_CLK_HZ * `RTC_SECOND_MS / `RTC_MS_PER_S)
`define RTC_SYNC_LEAD 32'd32
`endif

// [rtl/rtc_pkg.sv]
`default_nettype none
package rtc_pkg;
   typedef enum logic {BUS_WAIT, BUS_DONE} bus_state_t;
   typedef logic [1:0] win_ptr_t;
endpackage
`default_nettype wire

// [rtl/rtc_time_if.sv]
`default_nettype none
interface rtc_time_if;
   logic       run;
   logic [1:0] sel;
   logic       wrHi;
   logic       wrLo;
   logic [7:0] wrDataHi;
   logic [7:0] wrDataLo;
   logic [7:0] rdHi;
   logic [7:0] rdLo;
   logic       half_second_flag;
   logic       nearRoll;
   modport ctrl (output run, sel, wrHi, wrLo, wrDataHi, wrDataLo,
                 input rdHi, rdLo, half_second_flag, nearRoll);
   modport keeper (input run, sel, wrHi, wrLo, wrDataHi, wrDataLo,
                   output rdHi, rdLo, half_second_flag, nearRoll);
endinterface
`default_nettype wire

// [rtl/rtc_time_keeper.sv]
`include "rtc_params.svh"
`default_nettype none
module rtc_time_keeper
   import rtc_pkg::*;
#(
   parameter int unsigned SECOND_CYCLES = 32'(`RTC_SECOND_CYCLES)
) (
   input wire logic   clk_sys,
   input wire logic   reset_n,
   rtc_time_if.keeper tif
);
   logic [31:0] pre;
   logic [7:0]  sec, min, hour, wday, day, mon;
   logic        tick;

   assign tick = tif.run && (pre == SECOND_CYCLES - 32'd1);
   assign tif.half_second_flag = (pre >= SECOND_CYCLES / 32'd2);
   assign tif.nearRoll = tif.run && (pre >= SECOND_CYCLES - `RTC_SYNC_LEAD);

   // Writing the seconds byte restarts the second, so the half flag drops.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || (tif.wrLo && tif.sel == `RTC_PTR_MINUTES_SECONDS_FIELD)) begin //RULE_05
         pre <= '0;
      end else if (tick) begin
         pre <= '0;
      end else if (tif.run) begin //RULE_11
         pre <= pre + 32'd1;
      end
   end

   // A write in the same cycle as a tick wins; that tick is dropped.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         {sec, min, hour, wday} <= '0;
         day <= `RTC_DAY_MIN;
         mon <= `RTC_MON_MIN;
      end else if (tif.wrHi || tif.wrLo) begin //RULE_12
         if (tif.wrHi) begin
            if (tif.sel == 2'h0) min <= tif.wrDataHi;
            if (tif.sel == 2'h1) wday <= tif.wrDataHi;
            if (tif.sel == 2'h2) mon <= tif.wrDataHi;
         end
         if (tif.wrLo) begin
            if (tif.sel == 2'h0) sec <= tif.wrDataLo;
            if (tif.sel == 2'h1) hour <= tif.wrDataLo;
            if (tif.sel == 2'h2) day <= tif.wrDataLo;
         end
      end else if (tick) begin //RULE_11
         sec <= (sec == `RTC_SEC_MAX) ? '0 : sec + `RTC_FIELD_ONE;
         if (sec == `RTC_SEC_MAX) begin
            min <= (min == `RTC_MIN_MAX) ? '0 : min + `RTC_FIELD_ONE;
            if (min == `RTC_MIN_MAX) begin
               hour <= (hour == `RTC_HOUR_MAX) ? '0 : hour + `RTC_FIELD_ONE;
               if (hour == `RTC_HOUR_MAX) begin
                  wday <= (wday == `RTC_WDAY_MAX) ? '0 : wday + `RTC_FIELD_ONE;
                  day <= (day == `RTC_DAY_MAX) ? `RTC_DAY_MIN : day + `RTC_FIELD_ONE;
                  if (day == `RTC_DAY_MAX) begin
                     mon <= (mon == `RTC_MON_MAX) ? `RTC_MON_MIN : mon + `RTC_FIELD_ONE;
                  end
               end
            end
         end
      end
   end

   always_comb begin //RULE_08
      tif.rdHi = '0;
      tif.rdLo = '0;
      if (tif.sel == 2'h0) begin
         tif.rdHi = min;
         tif.rdLo = sec;
      end else if (tif.sel == 2'h1) begin
         tif.rdHi = wday;
         tif.rdLo = hour;
      end else if (tif.sel == 2'h2) begin
         tif.rdHi = mon;
         tif.rdLo = day;
      end
   end

   property p_hold_stopped;
      !tif.run && !tif.wrHi && !tif.wrLo |=> $stable({sec, min, hour, wday, day, mon});
   endproperty
   a_hold_stopped: assert property (@(posedge clk_sys) disable iff (!reset_n) p_hold_stopped) //RULE_11
      else $error("Time fields moved while the clock was stopped.");

   property p_store_seconds;
      tif.wrLo && tif.sel == `RTC_PTR_MINUTES_SECONDS_FIELD |=> sec == $past(tif.wrDataLo);
   endproperty
   a_store_seconds: assert property (@(posedge clk_sys) disable iff (!reset_n) p_store_seconds) //RULE_12
      else $error("Seconds byte was not stored.");
endmodule
`default_nettype wire

// [rtl/rtc_clock_pin.sv]
`default_nettype none
module rtc_clock_pin (
   input wire logic  clk_sys,
   input wire logic  reset_n,
   input wire logic  enable,
   input wire logic  selSeconds,
   input wire logic  secClock,
   input wire logic  alarmAsync,
   output var logic  pinOut,
   output var logic  pinOe_n
);
   logic alarmMeta, alarmSync;

   always_ff @(posedge clk_sys) begin
      alarmMeta <= reset_n ? alarmAsync : 1'b0;
      alarmSync <= reset_n ? alarmMeta : 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pinOut  <= 1'b0;
         pinOe_n <= 1'b1;
      end else begin
         pinOe_n <= !enable; //RULE_06
         pinOut  <= enable ? (selSeconds ? secClock : alarmSync) : 1'b0; //RULE_09 RULE_10
      end
   end

   property p_pin_sel;
      enable && selSeconds |=> pinOut == $past(secClock);
   endproperty
   a_pin_sel: assert property (@(posedge clk_sys) disable iff (!reset_n) p_pin_sel) //RULE_09
      else $error("Seconds clock not routed to the pin.");

   property p_pin_gate;
      !enable |=> pinOe_n && !pinOut;
   endproperty
   a_pin_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) p_pin_gate) //RULE_10
      else $error("Pin driven while output disabled.");
endmodule
`default_nettype wire

// [rtl/rtc_config_access.sv]
// Operation
// (RULE_01) Enable bit and value writes need write-enable.
// (RULE_02) Sync flag set while rollover may ripple.
// (RULE_03) Software reads twice while sync set.
// (RULE_04) Half-second flag high in second half.
// (RULE_05) Writing seconds byte clears half-second flag.
// (RULE_06) Output-enable bit drives the clock pin.
// (RULE_07) Window pointer decrements per value access, floors 00.
// (RULE_08) Pointer selects time field pair at value register.
// (RULE_09) Select bit picks seconds clock or alarm.
// (RULE_10) Pin driven only with output-enable set.
// (RULE_11) Time advances only while clock enable set.
// (RULE_12) Value writes land in pointed fields first.
`include "rtc_params.svh"
`default_nettype none
module rtc_config_access
   import rtc_pkg::*;
#(
   parameter int unsigned SECOND_CYCLES = 32'(`RTC_SECOND_CYCLES)
) (
   input wire logic         clk_sys,
   input wire logic         reset_n,
   input wire logic [3:0]   avs_address,
   input wire logic         avs_read,
   input wire logic         avs_write,
   input wire logic [31:0]  avs_writedata,
   input wire logic [3:0]   avs_byteenable,
   output var logic [31:0]  avs_readdata,
   output var logic         avs_waitrequest,
   input wire logic         alarmPulse,
   output var logic         clockOut,
   output var logic         clockOutOe_n
);
   bus_state_t busState;
   win_ptr_t   ptr;
   logic       enable;
   logic       wren;
   logic       outEnable;
   logic [7:0] cal;
   logic       srcSel;
   logic       pmpBuf;
   logic       request;
   logic       accept;
   logic       hitCfg;
   logic       hitPad;
   logic       hitVal;
   logic       wrCfg;
   logic       wrPad;
   logic       valAccess;
   logic       valOpen;
   logic [15:0] cfgWord;
   logic [15:0] padWord;
   logic [15:0] valWord;
   logic [31:0] next_readdata;

   rtc_time_if tif ();

   assign request = avs_read || avs_write;
   assign accept = (busState == BUS_DONE) && request;
   assign hitCfg = (avs_address == `RTC_OFS_CFG);
   assign hitPad = (avs_address == `RTC_OFS_PAD);
   assign hitVal = (avs_address == `RTC_OFS_VAL);
   assign wrCfg = accept && avs_write && hitCfg;
   assign wrPad = accept && avs_write && hitPad;
   assign valAccess = accept && hitVal;

   // Every access gets one wait state; the reply lands on the second edge.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         busState <= BUS_WAIT;
         avs_waitrequest <= 1'b1;
      end else begin
         unique case (busState)
            BUS_WAIT: begin
               if (request) begin
                  busState <= BUS_DONE;
                  avs_waitrequest <= 1'b0;
               end
            end
            BUS_DONE: begin
               busState <= BUS_WAIT;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // The old write-enable gates the enable bit, so one write cannot unlock
   // and flip the clock at once.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         enable <= 1'b0;
      end else if (wrCfg && avs_byteenable[1] && wren) begin //RULE_01
         enable <= avs_writedata[`RTC_EN_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wren <= 1'b0;
         outEnable <= 1'b0;
      end else if (wrCfg && avs_byteenable[1]) begin
         wren <= avs_writedata[`RTC_WREN_BIT];
         outEnable <= avs_writedata[`RTC_OE_BIT]; //RULE_06
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cal <= '0;
      end else if (wrCfg && avs_byteenable[0]) begin
         cal <= avs_writedata[`RTC_CAL_HI:0];
      end
   end

   // A direct pointer write takes the place of the access decrement.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ptr <= `RTC_PTR_MINUTES_SECONDS_FIELD;
      end else if (wrCfg && avs_byteenable[1]) begin
         ptr <= avs_writedata[`RTC_PTR_HI:`RTC_PTR_LO];
      end else if (valAccess && ptr != `RTC_PTR_MINUTES_SECONDS_FIELD) begin //RULE_07
         ptr <= ptr - `RTC_PTR_STEP;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         srcSel <= 1'b0;
         pmpBuf <= 1'b0;
      end else if (wrPad && avs_byteenable[0]) begin
         srcSel <= avs_writedata[`RTC_SEL_BIT]; //RULE_09
         pmpBuf <= avs_writedata[`RTC_PMP_BIT];
      end
   end

   // The reserved pointer value is a dead window: no field is written there.
   assign valOpen = valAccess && avs_write && wren && (ptr != `RTC_PTR_RSVD); //RULE_01
   assign tif.wrHi = valOpen && avs_byteenable[1]; //RULE_12
   assign tif.wrLo = valOpen && avs_byteenable[0]; //RULE_12
   assign tif.wrDataHi = avs_writedata[15:8];
   assign tif.wrDataLo = avs_writedata[7:0];
   assign tif.sel = ptr; //RULE_08
   assign tif.run = enable; //RULE_11

   always_comb begin
      cfgWord = '0;
      cfgWord[`RTC_EN_BIT] = enable;
      cfgWord[`RTC_WREN_BIT] = wren;
      cfgWord[`RTC_SYNC_BIT] = tif.nearRoll; //RULE_02
      cfgWord[`RTC_HALF_BIT] = tif.half_second_flag; //RULE_04
      cfgWord[`RTC_OE_BIT] = outEnable;
      cfgWord[`RTC_PTR_HI:`RTC_PTR_LO] = ptr;
      cfgWord[`RTC_CAL_HI:0] = cal;
   end

   always_comb begin
      padWord = '0;
      padWord[`RTC_SEL_BIT] = srcSel;
      padWord[`RTC_PMP_BIT] = pmpBuf;
   end

   assign valWord = {tif.rdHi, tif.rdLo}; //RULE_08

   // Unmapped addresses read as zero and swallow writes.
   always_comb begin
      next_readdata = '0;
      if (hitCfg) begin
         next_readdata[15:0] = cfgWord;
      end else if (hitPad) begin
         next_readdata[15:0] = padWord;
      end else if (hitVal) begin
         next_readdata[15:0] = valWord;
      end
   end

   // Read data is caught one edge before release and holds for the bench.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         avs_readdata <= '0;
      end else if (busState == BUS_WAIT && avs_read) begin
         avs_readdata <= next_readdata;
      end
   end

   rtc_time_keeper #(
      .SECOND_CYCLES (SECOND_CYCLES)
   ) u_keeper (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .tif     (tif.keeper)
   );

   rtc_clock_pin u_pin (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .enable     (outEnable),
      .selSeconds (srcSel),
      .secClock   (tif.half_second_flag),
      .alarmAsync (alarmPulse),
      .pinOut     (clockOut),
      .pinOe_n    (clockOutOe_n)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   sequence s_cfg_read_taken;
      busState == BUS_WAIT && avs_read && hitCfg;
   endsequence

   sequence s_cfg_write_locked;
      wrCfg && avs_byteenable[1] && !wren;
   endsequence

   property p_enable_locked;
      s_cfg_write_locked |=> enable == $past(enable);
   endproperty
   a_enable_locked: assert property (p_enable_locked) //RULE_01
      else $error("Enable bit changed while writes locked.");

   property p_value_locked;
      valAccess && avs_write && !wren |-> !tif.wrHi && !tif.wrLo;
   endproperty
   a_value_locked: assert property (p_value_locked) //RULE_01
      else $error("Value write passed while locked.");

   property p_sync_read;
      s_cfg_read_taken ##1 !avs_waitrequest
         |-> avs_readdata[`RTC_SYNC_BIT] == $past(tif.nearRoll);
   endproperty
   a_sync_read: assert property (p_sync_read) //RULE_02
      else $error("Sync flag read back wrong.");

   property p_half_read;
      s_cfg_read_taken |=> avs_readdata[`RTC_HALF_BIT] == $past(tif.half_second_flag);
   endproperty
   a_half_read: assert property (p_half_read) //RULE_04
      else $error("Half-second flag read back wrong.");

   property p_half_clear;
      tif.wrLo && ptr == `RTC_PTR_MINUTES_SECONDS_FIELD |=> !tif.half_second_flag;
   endproperty
   a_half_clear: assert property (p_half_clear) //RULE_05
      else $error("Half-second flag not cleared by seconds write.");

   property p_ptr_dec;
      valAccess && ptr != `RTC_PTR_MINUTES_SECONDS_FIELD |=> ptr == $past(ptr) - `RTC_PTR_STEP;
   endproperty
   a_ptr_dec: assert property (p_ptr_dec) //RULE_07
      else $error("Window pointer did not step down.");

   property p_ptr_floor;
      valAccess && ptr == `RTC_PTR_MINUTES_SECONDS_FIELD |=> ptr == `RTC_PTR_MINUTES_SECONDS_FIELD;
   endproperty
   a_ptr_floor: assert property (p_ptr_floor) //RULE_07
      else $error("Window pointer moved below zero.");

   property p_pin_off;
      !outEnable ##1 !outEnable |-> clockOutOe_n && !clockOut;
   endproperty
   a_pin_off: assert property (p_pin_off) //RULE_06
      else $error("Pin enabled while output-enable clear.");

   property p_pin_on;
      outEnable |=> !clockOutOe_n;
   endproperty
   a_pin_on: assert property (p_pin_on) //RULE_10
      else $error("Pin not enabled one cycle after output-enable.");

   property p_bus_answer;
      busState == BUS_WAIT && request |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("Bus answer timing wrong.");

   // The read path, value and config writes and the pin route are checked here, where the whole register map is visible.
   sequence s_val_read_taken;
      busState == BUS_WAIT && avs_read && hitVal;
   endsequence

   sequence s_pad_read_taken;
      busState == BUS_WAIT && avs_read && hitPad;
   endsequence

   sequence s_unmapped_read_taken;
      busState == BUS_WAIT && avs_read && !hitCfg && !hitPad && !hitVal;
   endsequence

   property p_upper_zero;
      !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("Upper read lanes not zero.");

   property p_window_reserved;
      s_val_read_taken ##0 ptr == `RTC_PTR_RSVD |=> avs_readdata[15:0] == 16'h0000;
   endproperty
   a_window_reserved: assert property (p_window_reserved) //RULE_08
      else $error("Reserved window did not read as zero.");

   property p_reserved_write;
      valAccess && ptr == `RTC_PTR_RSVD |-> !tif.wrHi && !tif.wrLo;
   endproperty
   a_reserved_write: assert property (p_reserved_write) //RULE_08
      else $error("Write landed through the reserved window.");

   property p_value_write;
      valAccess && avs_write && wren && ptr != `RTC_PTR_RSVD
         |-> tif.sel == ptr && tif.wrHi == avs_byteenable[1] && tif.wrLo == avs_byteenable[0];
   endproperty
   a_value_write: assert property (p_value_write) //RULE_12
      else $error("Permitted value write not passed to the fields.");

   property p_enable_open;
      wrCfg && avs_byteenable[1] && wren |=> enable == $past(avs_writedata[`RTC_EN_BIT]);
   endproperty
   a_enable_open: assert property (p_enable_open) //RULE_01
      else $error("Unlocked enable write was dropped.");

   property p_sync_off;
      !enable |-> !tif.nearRoll;
   endproperty
   a_sync_off: assert property (p_sync_off) //RULE_02
      else $error("Sync flag set while the clock is stopped.");

   property p_wait_idle;
      busState == BUS_WAIT && !request |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle)
      else $error("Wait request dropped with no access.");

   property p_unmapped_read;
      s_unmapped_read_taken |=> avs_readdata == 32'h00000000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("Unmapped address did not read as zero.");

   property p_pad_read;
      s_pad_read_taken |=> avs_readdata[`RTC_SEL_BIT] == $past(srcSel);
   endproperty
   a_pad_read: assert property (p_pad_read) //RULE_09
      else $error("Source select read back wrong.");

   property p_ptr_load;
      wrCfg && avs_byteenable[1] |=> ptr == $past(avs_writedata[`RTC_PTR_HI:`RTC_PTR_LO]);
   endproperty
   a_ptr_load: assert property (p_ptr_load) //RULE_07
      else $error("Window pointer write not taken.");

   property p_seconds_route;
      outEnable && srcSel |=> clockOut == $past(tif.half_second_flag);
   endproperty
   a_seconds_route: assert property (p_seconds_route) //RULE_09
      else $error("Seconds clock missing at the pin.");
endmodule
`default_nettype wire

// [sim/rtc_config_access_tb.sv]
`default_nettype none
module rtc_config_access_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // Short second so that two rollovers fit in a brief run.
   localparam int SECS = 200;
   logic        clk_sys;
   logic        reset_n;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        alarmPulse;
   logic        clockOut;
   logic        clockOutOe_n;
   int          nErrors;
   int          numChecks;
   int          seed;
   int          hiF[3];
   int          loF[3];
   int          ptr;
   int          en;
   int          wren;
   int          oe;
   int          cal;
   int          pad;
   int          cnt;
   logic [15:0] rd;
   logic [15:0] expV;
   logic [15:0] v;

   rtc_config_access #(.SECOND_CYCLES(SECS)) i_dut (
      .clk_sys         (clk_sys),
      .reset_n         (reset_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .alarmPulse      (alarmPulse),
      .clockOut        (clockOut),
      .clockOutOe_n    (clockOutOe_n)
   );

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d, errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic int rnd(input int m);
      return ($random(seed) & 32'h7FFFFFFF) % m;
   endfunction

   // One bus access; the model is updated after the expected value is taken.
   task automatic acc(input logic wr, input logic [3:0] addr, input logic [15:0] wdata, input logic [3:0] be);
      int n;
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {16'h0000, wdata};
      avs_byteenable <= be;
      case (addr)
         4'h0: expV = {en[0], 1'b0, wren[0], 2'b00, oe[0], ptr[1:0], cal[7:0]};
         4'h4: expV = {14'h0000, pad[1:0]};
         4'h8: expV = (ptr == 3) ? 16'h0000 : {hiF[ptr][7:0], loF[ptr][7:0]};
         default: expV = 16'h0000;
      endcase
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 16);
      if (avs_waitrequest !== 1'b0) begin
         nErrors++;
         $display("unexpected at %0t: bus answer missing", $time);
         close_out();
      end
      rd = avs_readdata[15:0];
      if (!wr) check(avs_readdata[31:16], 16'h0000);
      if (wr && addr == 4'h8 && wren == 1 && ptr != 3) begin
         if (be[1]) hiF[ptr] = wdata[15:8];
         if (be[0]) loF[ptr] = wdata[7:0];
      end
      if (addr == 4'h8 && ptr != 0) ptr--;
      if (wr && addr == 4'h0) begin
         if (wren == 1) en = wdata[15];
         wren = wdata[13];
         oe = wdata[10];
         ptr = wdata[9:8];
         cal = wdata[7:0];
      end
      if (wr && addr == 4'h4) pad = wdata[1:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   initial begin
      reset_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      alarmPulse = 1'b0;
      seed = 32'h31EB;
      nErrors = 0;
      numChecks = 0;
      hiF = '{0, 0, 1};
      loF = '{0, 0, 1};
      {ptr, en, wren, oe, cal, pad} = {6{32'sd0}};
      repeat (3) @(posedge clk_sys);
      check({14'h0000, clockOut, clockOutOe_n}, 16'h0001);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      acc(1'b0, 4'h0, 16'h0000, 4'h3);
      check(rd, 16'h0000);
      acc(1'b0, 4'h4, 16'h0000, 4'h3);
      check(rd, 16'h0000);
      acc(1'b0, 4'h8, 16'h0000, 4'h3);
      check(rd, expV);
      acc(1'b0, 4'hC, 16'h0000, 4'h3);
      check(rd, 16'h0000);
      // Locked: enable bit and value writes must both be dropped.
      acc(1'b1, 4'h0, 16'h8200, 4'h3);
      acc(1'b0, 4'h0, 16'h0000, 4'h3);
      check(rd & 16'hE7FF, expV);
      acc(1'b1, 4'h8, 16'h0305, 4'h3);
      acc(1'b1, 4'h0, 16'h2200 | 16'(rnd(256)), 4'h3);
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, 4'h8, 16'h0000, 4'h3);
         check(rd, expV);
      end
      acc(1'b1, 4'h0, 16'h2200, 4'h3);
      for (int p = 2; p >= 0; p--) begin
         case (p)
            2: v = {8'(1 + rnd(12)), 8'(1 + rnd(31))};
            1: v = {8'(rnd(7)), 8'(rnd(24))};
            default: v = {8'(rnd(60)), 8'(rnd(59))};
         endcase
         acc(1'b1, 4'h8, v, 4'h3);
      end
      acc(1'b0, 4'h0, 16'h0000, 4'h3);
      check(rd & 16'hE7FF, expV & 16'hE7FF);
      acc(1'b1, 4'h0, 16'h2300, 4'h3);
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, 4'h8, 16'h0000, 4'h3);
         check(rd, expV);
      end
      // Run the counter; the lower-byte write restarts the second.
      acc(1'b1, 4'h0, 16'hA000, 4'h3);
      // Let the flag rise first, so that the write has something to clear.
      repeat (120) @(posedge clk_sys);
      acc(1'b1, 4'h8, 16'(rnd(59)), 4'h1);
      acc(1'b0, 4'h0, 16'h0000, 4'h3);
      check(rd & 16'hE7FF, expV & 16'hE7FF);
      check({14'h0000, rd[12:11]}, 16'h0000);
      repeat (135) @(posedge clk_sys);
      acc(1'b0, 4'h0, 16'h0000, 4'h3);
      check({14'h0000, rd[12:11]}, 16'h0001);
      repeat (40) @(posedge clk_sys);
      acc(1'b0, 4'h0, 16'h0000, 4'h3);
      check({14'h0000, rd[12:11]}, 16'h0003);
      acc(1'b0, 4'h8, 16'h0000, 4'h3);
      check(rd, expV);
      v = rd;
      acc(1'b0, 4'h8, 16'h0000, 4'h3);
      check(rd, v);
      repeat (20) @(posedge clk_sys);
      loF[0]++;
      acc(1'b0, 4'h8, 16'h0000, 4'h3);
      check(rd, expV);
      acc(1'b1, 4'h0, 16'h2000, 4'h3);
      repeat (250) @(posedge clk_sys);
      acc(1'b0, 4'h8, 16'h0000, 4'h3);
      check(rd, expV);
      // Pin: alarm path, then the seconds square wave.
      acc(1'b1, 4'h4, 16'h0000 | 16'(rnd(2)), 4'h3);
      acc(1'b0, 4'h4, 16'h0000, 4'h3);
      check(rd, expV);
      alarmPulse <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check({14'h0000, clockOut, clockOutOe_n}, 16'h0001);
      acc(1'b1, 4'h0, 16'h2400, 4'h3);
      @(posedge clk_sys);
      check({14'h0000, clockOut, clockOutOe_n}, 16'h0002);
      alarmPulse <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check({14'h0000, clockOut, clockOutOe_n}, 16'h0000);
      acc(1'b1, 4'h4, 16'h0002, 4'h3);
      acc(1'b1, 4'h0, 16'hA400, 4'h3);
      alarmPulse <= 1'b1;
      cnt = 0;
      repeat (SECS) begin
         @(posedge clk_sys);
         if (clockOut === 1'b1) cnt++;
      end
      check({15'h0000, cnt >= SECS / 2 - 3 && cnt <= SECS / 2 + 3}, 16'h0001);
      acc(1'b1, 4'h0, 16'h2000, 4'h3);
      repeat (3) @(posedge clk_sys);
      check({14'h0000, clockOut, clockOutOe_n}, 16'h0001);
      close_out();
   end
endmodule
`default_nettype wire
